/* monitor_config_regs.vh */
// Register offsets, field positions, reset values and timing counts.
`ifndef MONITOR_CONFIG_REGS_VH
`define MONITOR_CONFIG_REGS_VH
`define ADDR_FAN_PIN_CFG 8'h05
`define ADDR_ALARM_CFG 8'h06
`define ADDR_PACING_CTRL 8'h07
`define ADDR_CHAN_DISABLE 8'h08
`define ADDR_PACING_COUNT 8'h0B
`define ADDR_MAIN_CFG 8'h00
`define RST_FAN_PIN_CFG 8'h14
`define RST_ALARM_LOW 4'h1
`define RST_PACING_CTRL 8'h40
`define RST_CHAN_DISABLE 8'h00
`define RST_PACING_COUNT 8'h40
`define BIT_FIRST_MODE 0
`define BIT_SECOND_MODE 1
`define BIT_ALARM_EN 6
`define BIT_RESET_EN 7
`define BIT_ALARM_STATUS 0
`define BIT_ALARM_POL 1
`define BIT_ALARM_ONESHOT 2
`define BIT_HIGH_RES 3
`define BIT_CONTINUOUS 0
`define BIT_SOFT_RESET 4
`define DELAY_UNIT_US 1420
`define DELAY_UNIT_CYCLES (`DELAY_UNIT_US * 100)
`define RESET_PULSE_CYCLES 16'd1000
`endif

/* tach_input.v */
// One fan input: pulse divider in count mode, polarity in level mode.
`include "monitor_config_regs.vh"
module tach_input (
	input wire i_clk,
	input wire i_reset,
	input wire i_pin,
	input wire i_level_mode,
	input wire [1:0] i_field,
	output reg o_pulse,
	output reg o_level
);
	reg sync1_q, sync2_q, prev_q;
	reg [2:0] div_q;
	wire rise = sync2_q & ~prev_q;
	reg [2:0] mask;
	always @* begin
		case (i_field)
			2'h0: mask = 3'h0;
			2'h1: mask = 3'h1;
			2'h2: mask = 3'h3;
			default: mask = 3'h7;
		endcase
	end
	always @(posedge i_clk) begin
		if (i_reset) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q <= 1'b0;
			div_q <= 3'h0;
			o_pulse <= 1'b0;
			o_level <= 1'b0;
		end else begin
			sync1_q <= i_pin;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
			// R3
			o_level <= i_level_mode & (i_field[0] ? ~sync2_q : sync2_q);
			o_pulse <= 1'b0;
			if (!i_level_mode && rise) begin // R1
				if ((div_q & mask) == mask) begin // R2
					o_pulse <= 1'b1;
					div_q <= 3'h0;
				end else begin
					div_q <= div_q + 3'h1;
				end
			end
		end
	end
endmodule // tach_input

/* pacing_timer.v */
// Round pacing: back to back or a programmed delay between rounds.
`include "monitor_config_regs.vh"
module pacing_timer #(
	parameter UNIT_CYCLES = `DELAY_UNIT_CYCLES
) (
	input wire i_clk,
	input wire i_reset,
	input wire i_continuous,
	input wire [7:0] i_count,
	output reg o_start
);
	reg [31:0] unit_q;
	reg [11:0] units_q;
	wire [11:0] total = {1'b0, i_count, 3'h0} + 12'd6;
	always @(posedge i_clk) begin
		if (i_reset) begin
			unit_q <= 32'h0;
			units_q <= 12'h0;
			o_start <= 1'b0;
		end else if (i_continuous) begin // R13 R22
			o_start <= 1'b1;
			unit_q <= 32'h0;
			units_q <= 12'h0;
		end else begin
			o_start <= 1'b0;
			// R14
			if (unit_q >= UNIT_CYCLES - 1) begin
				unit_q <= 32'h0;
				if (units_q + 12'd1 >= total) begin
					units_q <= 12'h0;
					o_start <= 1'b1;
				end else begin
					units_q <= units_q + 12'd1;
				end
			end else begin
				unit_q <= unit_q + 32'h1;
			end
		end
	end
endmodule // pacing_timer

/* monitor_config_registers.v */
// Configuration register bank of the hardware monitor.
`include "monitor_config_regs.vh"
// What this block does
// R1: Mode bit per fan: level or count.
// R2: Divisor field selects divide by 1,2,4,8.
// R3: Level mode: field 01 active low.
// R4: Bit7 set, bit6 clear: reset output.
// R5: Bit6 set, bit7 clear: alarm output.
// R6: Both bits set: pin disabled.
// R7: Fan and pin config resets to 14h.
// R8: Alarm status bit mirrors pin level in alarm mode; reads one in any other mode.
// R9: Alarm polarity bit: one is active high.
// R10: Alarm mode: one-shot or comparator.
// R11: Resolution bit: eleven or eight bits.
// R12: Bits 7:4 hold fraction temperature bits.
// R13: Continuous bit runs rounds back to back.
// R14: Otherwise wait 1.42*(8N+6) ms.
// R15: Software writes pacing reserved bits zero.
// R16: Pacing control resets to 40h.
// R17: Disabled voltage channel: no conversion, zero.
// R18: Disabled temperature: no conversion, zero.
// R19: Channel disable resets to zero.
// R20: Alarm config low nibble resets to 1.
// R21: Soft reset pulses only in reset mode.
// R22: Continuous mode ignores the delay count.
// R23: Disabled pin stays inactive, not driven.
module monitor_config_registers #(
	parameter UNIT_CYCLES = `DELAY_UNIT_CYCLES
) (
	input wire I_SYS_CLK,
	input wire I_RESET,
	input wire i_WR,
	input wire i_RD,
	input wire [7:0] i_ADDR,
	input wire [7:0] i_WDATA,
	output reg [7:0] o_RDATA,
	input wire i_FIRST_TACH,
	input wire i_SECOND_TACH,
	input wire i_OVERTEMP,
	input wire [11:0] i_TEMP_READING,
	input wire i_TEMP_VALID,
	input wire [9:0] i_CHAN_READING,
	input wire [2:0] i_CHAN_SEL,
	input wire i_CHAN_LIMIT_ERR,
	input wire i_TEMP_LIMIT_ERR,
	output reg [9:0] o_CHAN_VALUE,
	output reg o_CHAN_ERR,
	output reg o_TEMP_ERR,
	output reg [7:0] o_CONVERT_ENABLE,
	output reg o_ROUND_START,
	output reg o_FIRST_PULSE,
	output reg o_FIRST_LEVEL,
	output reg o_SECOND_PULSE,
	output reg o_SECOND_LEVEL,
	output reg o_HIGH_RES,
	output reg o_PIN_OUT,
	output reg o_PIN_OE_N
);
	reg [7:0] fan_pin_q;
	reg [3:0] alarm_ctl_q;
	reg [3:0] fraction_q;
	reg [7:0] pacing_q;
	reg [7:0] count_q;
	reg [7:0] disable_q;
	reg soft_reset_q;
	reg [15:0] pulse_cnt_q;
	reg alarm_active_q;
	reg ot_s1_q, ot_s2_q, ot_prev_q;
	wire reset_mode = fan_pin_q[`BIT_RESET_EN] & ~fan_pin_q[`BIT_ALARM_EN];
	wire alarm_mode = fan_pin_q[`BIT_ALARM_EN] & ~fan_pin_q[`BIT_RESET_EN];
	wire alarm_level = alarm_ctl_q[`BIT_ALARM_POL] ? alarm_active_q :
		~alarm_active_q;
	wire first_pulse, first_level, second_pulse, second_level, round_start;

	tach_input u_first (
		.i_clk(I_SYS_CLK),
		.i_reset(I_RESET),
		.i_pin(i_FIRST_TACH),
		.i_level_mode(fan_pin_q[`BIT_FIRST_MODE]),
		.i_field(fan_pin_q[3:2]),
		.o_pulse(first_pulse),
		.o_level(first_level)
	);

	tach_input u_second (
		.i_clk(I_SYS_CLK),
		.i_reset(I_RESET),
		.i_pin(i_SECOND_TACH),
		.i_level_mode(fan_pin_q[`BIT_SECOND_MODE]),
		.i_field(fan_pin_q[5:4]),
		.o_pulse(second_pulse),
		.o_level(second_level)
	);

	pacing_timer #(
		.UNIT_CYCLES(UNIT_CYCLES)
	) u_pacing (
		.i_clk(I_SYS_CLK),
		.i_reset(I_RESET),
		.i_continuous(pacing_q[`BIT_CONTINUOUS]),
		.i_count(count_q),
		.o_start(round_start)
	);

	// Register writes and power-on values.
	always @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			fan_pin_q <= `RST_FAN_PIN_CFG; // R7
			alarm_ctl_q <= `RST_ALARM_LOW; // R20
			pacing_q <= `RST_PACING_CTRL; // R16
			disable_q <= `RST_CHAN_DISABLE; // R19
			count_q <= `RST_PACING_COUNT;
		end else if (i_WR) begin
			case (i_ADDR)
				`ADDR_FAN_PIN_CFG: fan_pin_q <= i_WDATA;
				`ADDR_ALARM_CFG: alarm_ctl_q <= {i_WDATA[3:1], 1'b0};
				// Reserved bits are stored as written; software keeps them zero.
				`ADDR_PACING_CTRL: pacing_q <= i_WDATA; // R15
				`ADDR_CHAN_DISABLE: disable_q <= i_WDATA;
				`ADDR_PACING_COUNT: count_q <= i_WDATA;
				default: begin
				end
			endcase
		end
	end

	// Fraction bits follow each new temperature result.
	always @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			fraction_q <= 4'h0;
		end else if (disable_q[7]) begin
			fraction_q <= 4'h0; // R18
		end else if (i_TEMP_VALID) begin
			// R11 R12
			fraction_q <= alarm_ctl_q[`BIT_HIGH_RES] ? i_TEMP_READING[3:0] :
				{i_TEMP_READING[0], 3'h0};
		end else if (i_WR && i_ADDR == `ADDR_ALARM_CFG) begin
			fraction_q <= i_WDATA[7:4];
		end
	end

	// Software reset pulse; the request clears when the pulse ends.
	always @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			soft_reset_q <= 1'b0;
			pulse_cnt_q <= 16'h0;
		end else if (soft_reset_q) begin
			if (pulse_cnt_q == `RESET_PULSE_CYCLES - 16'd1) begin
				soft_reset_q <= 1'b0; // R21
				pulse_cnt_q <= 16'h0;
			end else begin
				pulse_cnt_q <= pulse_cnt_q + 16'h1;
			end
		end else if (i_WR && i_ADDR == `ADDR_MAIN_CFG &&
			i_WDATA[`BIT_SOFT_RESET] && reset_mode) begin
			soft_reset_q <= 1'b1; // R21
		end
	end

	// Alarm condition: comparator follows, one-shot latches until a read.
	always @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			ot_s1_q <= 1'b0;
			ot_s2_q <= 1'b0;
			ot_prev_q <= 1'b0;
			alarm_active_q <= 1'b0;
		end else begin
			ot_s1_q <= i_OVERTEMP;
			ot_s2_q <= ot_s1_q;
			ot_prev_q <= ot_s2_q;
			if (!alarm_ctl_q[`BIT_ALARM_ONESHOT]) begin
				alarm_active_q <= ot_s2_q; // R10
			end else if (ot_s2_q & ~ot_prev_q) begin
				alarm_active_q <= 1'b1; // R10
			end else if (i_RD && i_ADDR == `ADDR_ALARM_CFG) begin
				alarm_active_q <= 1'b0;
			end
		end
	end

	// Shared pin and the remaining outputs.
	always @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			o_PIN_OUT <= 1'b1;
			o_PIN_OE_N <= 1'b1;
			o_RDATA <= 8'h00;
			o_CHAN_VALUE <= 10'h000;
			o_CHAN_ERR <= 1'b0;
			o_TEMP_ERR <= 1'b0;
			o_CONVERT_ENABLE <= 8'hFF;
			o_ROUND_START <= 1'b0;
			o_FIRST_PULSE <= 1'b0;
			o_FIRST_LEVEL <= 1'b0;
			o_SECOND_PULSE <= 1'b0;
			o_SECOND_LEVEL <= 1'b0;
			o_HIGH_RES <= 1'b0;
		end else begin
			if (reset_mode) begin
				o_PIN_OUT <= ~soft_reset_q; // R4
				o_PIN_OE_N <= 1'b0;
			end else if (alarm_mode) begin
				o_PIN_OUT <= alarm_level; // R5 R9
				o_PIN_OE_N <= 1'b0;
			end else begin
				o_PIN_OUT <= 1'b1; // R6 R23
				o_PIN_OE_N <= 1'b1;
			end
			o_CONVERT_ENABLE <= ~disable_q; // R17 R18
			o_CHAN_VALUE <= disable_q[i_CHAN_SEL] ? 10'h000 : i_CHAN_READING;
			o_CHAN_ERR <= i_CHAN_LIMIT_ERR & ~disable_q[i_CHAN_SEL]; // R17
			o_TEMP_ERR <= i_TEMP_LIMIT_ERR & ~disable_q[7]; // R18
			o_ROUND_START <= round_start;
			o_FIRST_PULSE <= first_pulse;
			o_FIRST_LEVEL <= first_level;
			o_SECOND_PULSE <= second_pulse;
			o_SECOND_LEVEL <= second_level;
			o_HIGH_RES <= alarm_ctl_q[`BIT_HIGH_RES]; // R11
			case (i_ADDR)
				`ADDR_FAN_PIN_CFG: o_RDATA <= fan_pin_q;
				// Outside alarm mode the status shows the idle, high pin.
				`ADDR_ALARM_CFG: o_RDATA <= {fraction_q, alarm_ctl_q[3:1],
					alarm_mode ? alarm_level : 1'b1}; // R8 R20
				`ADDR_PACING_CTRL: o_RDATA <= pacing_q;
				`ADDR_CHAN_DISABLE: o_RDATA <= disable_q;
				`ADDR_PACING_COUNT: o_RDATA <= count_q;
				`ADDR_MAIN_CFG: o_RDATA <= {3'h0, soft_reset_q, 4'h0};
				default: o_RDATA <= 8'h00;
			endcase
		end
	end
endmodule // monitor_config_registers

/* monitor_config_registers_asserts.sv */
// Checker for the monitor configuration register bank.
module monitor_config_registers_asserts (
	input wire I_SYS_CLK,
	input wire I_RESET,
	input wire i_WR,
	input wire [7:0] i_ADDR,
	input wire [7:0] i_WDATA,
	input wire [7:0] o_RDATA,
	input wire [2:0] i_CHAN_SEL,
	input wire [9:0] o_CHAN_VALUE,
	input wire o_CHAN_ERR,
	input wire [7:0] o_CONVERT_ENABLE,
	input wire o_ROUND_START,
	input wire o_PIN_OUT,
	input wire o_PIN_OE_N
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [7:0] pin_q;
	reg [7:0] pace_q;
	reg [7:0] dis_q;
	wire [1:0] mode = pin_q[7:6];
	// Shadows follow the same writes as the bank, so they hold its state.
	always @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			pin_q <= 8'h14;
			pace_q <= 8'h40;
			dis_q <= 8'h00;
		end else if (i_WR) begin
			if (i_ADDR == 8'h05) pin_q <= i_WDATA;
			if (i_ADDR == 8'h07) pace_q <= i_WDATA;
			if (i_ADDR == 8'h08) dis_q <= i_WDATA;
		end
	end
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RESET);
	sequence s_soft_req;
		mode == 2'b10 && i_WR && i_ADDR == 8'h00 && i_WDATA[4];
	endsequence
	sequence s_cont_held;
		pace_q[0] [*3];
	endsequence
	property p_pin_off;
		mode[1] == mode[0] |=> o_PIN_OE_N;
	endproperty
	property p_rst_mode;
		mode == 2'b10 |=> !o_PIN_OE_N;
	endproperty
	property p_alarm_mode;
		mode == 2'b01 |=> !o_PIN_OE_N;
	endproperty
	property p_rd_pin;
		i_ADDR == 8'h05 |=> o_RDATA == $past(pin_q);
	endproperty
	property p_conv_en;
		dis_q == $past(dis_q) |=> o_CONVERT_ENABLE == ~$past(dis_q);
	endproperty
	property p_chan_gate;
		i_CHAN_SEL != 3'd7 && dis_q[i_CHAN_SEL]
			|=> o_CHAN_VALUE == 10'h000 && !o_CHAN_ERR;
	endproperty
	property p_cont;
		s_cont_held |=> o_ROUND_START;
	endproperty
	property p_soft;
		s_soft_req |-> ##[1:4] !o_PIN_OUT;
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("pin driven");
	a_rst_mode: assert property (p_rst_mode) else $error("no reset");
	a_alarm_mode: assert property (p_alarm_mode) else $error("no alarm");
	a_rd_pin: assert property (p_rd_pin) else $error("bad read");
	a_conv_en: assert property (p_conv_en) else $error("bad enable");
	a_chan_gate: assert property (p_chan_gate) else $error("not gated");
	a_cont: assert property (p_cont) else $error("round gap");
	a_soft: assert property (p_soft) else $error("no pulse");
endmodule // monitor_config_registers_asserts
bind monitor_config_registers monitor_config_registers_asserts
	i_monitor_config_registers_asserts (.I_SYS_CLK(I_SYS_CLK),
	.I_RESET(I_RESET), .i_WR(i_WR), .i_ADDR(i_ADDR), .i_WDATA(i_WDATA),
	.o_RDATA(o_RDATA), .i_CHAN_SEL(i_CHAN_SEL), .o_CHAN_ERR(o_CHAN_ERR),
	.o_CHAN_VALUE(o_CHAN_VALUE), .o_CONVERT_ENABLE(o_CONVERT_ENABLE),
	.o_ROUND_START(o_ROUND_START), .o_PIN_OUT(o_PIN_OUT),
	.o_PIN_OE_N(o_PIN_OE_N));

/* host_model.sv */
// Host model that reaches the register bank with write and read strobes.
module host_model (
	input wire i_clk,
	input wire [7:0] i_rdata,
	output logic o_wr,
	output logic o_rd,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
	end
	task wr_reg(input [7:0] a, input [7:0] d);
		@(posedge i_clk);
		#1;
		o_addr = a;
		o_wdata = (a == 8'h07) ? (d & 8'h01) : d;
		o_wr = 1'b1;
		@(posedge i_clk);
		#1;
		o_wr = 1'b0;
		o_wdata = ~o_wdata;
	endtask
	task rd_reg(input [7:0] a, output [7:0] d);
		@(posedge i_clk);
		#1;
		o_addr = a;
		o_rd = 1'b1;
		@(posedge i_clk);
		#1;
		o_rd = 1'b0;
		d = i_rdata;
	endtask
endmodule // host_model

/* tb_monitor_config_registers.sv */
// Self-checking bench for the monitor configuration register bank.
module tb_monitor_config_registers;
	timeunit 1ns;
	timeprecision 1ps;
	localparam UNIT = 4;
	logic clk, rst, wr, rd, ft, st, ot, le, te, cerr, terr, rs;
	logic fp, fl, sp, sl, hr, po, poe, tv;
	logic [11:0] tr;
	logic [7:0] addr, wdata, rdata, ce, d;
	logic [2:0] sel;
	logic [9:0] rdg, cv;
	int n_mismatch = 0;
	int n_tests = 0;
	int npf, nps, n;
	host_model i_host_model (.i_clk(clk), .i_rdata(rdata), .o_wr(wr),
		.o_rd(rd), .o_addr(addr), .o_wdata(wdata));
	monitor_config_registers #(.UNIT_CYCLES(UNIT))
		i_monitor_config_registers (.I_SYS_CLK(clk), .I_RESET(rst),
		.i_WR(wr), .i_RD(rd), .i_ADDR(addr), .i_WDATA(wdata),
		.o_RDATA(rdata), .i_FIRST_TACH(ft), .i_SECOND_TACH(st),
		.i_OVERTEMP(ot), .i_TEMP_READING(tr), .i_TEMP_VALID(tv),
		.i_CHAN_READING(rdg), .i_CHAN_SEL(sel), .i_CHAN_LIMIT_ERR(le),
		.i_TEMP_LIMIT_ERR(te), .o_CHAN_VALUE(cv), .o_CHAN_ERR(cerr),
		.o_TEMP_ERR(terr), .o_CONVERT_ENABLE(ce), .o_ROUND_START(rs),
		.o_FIRST_PULSE(fp), .o_FIRST_LEVEL(fl), .o_SECOND_PULSE(sp),
		.o_SECOND_LEVEL(sl), .o_HIGH_RES(hr), .o_PIN_OUT(po),
		.o_PIN_OE_N(poe));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (fp) npf++;
		if (sp) nps++;
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task rc(input [7:0] a, input [7:0] e);
		i_host_model.rd_reg(a, d);
		chk(d, e);
	endtask
	task t_reset;
		rc(8'h05, 8'h14);
		rc(8'h07, 8'h40);
		rc(8'h08, 8'h00);
		i_host_model.rd_reg(8'h06, d);
		chk(d[3:0], 4'h1);
		chk({ce, poe}, 9'h1FF);
		i_host_model.wr_reg(8'h0F, 8'h5A);
		rc(8'h0F, 8'h00);
	endtask
	task t_pin;
		i_host_model.wr_reg(8'h00, 8'h10);
		cyc(3);
		chk(po, 1'b1);
		i_host_model.wr_reg(8'h05, 8'h80);
		cyc(1);
		chk({poe, po}, 2'b01);
		i_host_model.wr_reg(8'h00, 8'h10);
		cyc(2);
		chk(po, 1'b0);
		cyc(990);
		chk(po, 1'b0);
		cyc(12);
		chk(po, 1'b1);
		rc(8'h00, 8'h00);
		i_host_model.wr_reg(8'h06, 8'h02);
		ot = 1'b1;
		i_host_model.wr_reg(8'h05, 8'h40);
		cyc(4);
		chk({poe, po}, 2'b01);
		rc(8'h06, 8'h03);
		i_host_model.wr_reg(8'h06, 8'h00);
		cyc(2);
		chk(po, 1'b0);
		ot = 1'b0;
		cyc(4);
		chk(po, 1'b1);
		i_host_model.wr_reg(8'h06, 8'h04);
		ot = 1'b1;
		cyc(4);
		ot = 1'b0;
		cyc(4);
		chk(po, 1'b0);
		i_host_model.wr_reg(8'h06, 8'h08);
		cyc(1);
		chk(hr, 1'b1);
		i_host_model.wr_reg(8'h05, 8'hC0);
		cyc(1);
		chk(poe, 1'b1);
		tr = 12'hABC;
		tv = 1'b1;
		cyc(1);
		tv = 1'b0;
		rc(8'h06, 8'hC9);
		i_host_model.wr_reg(8'h06, 8'h00);
		tr = 12'h001;
		tv = 1'b1;
		cyc(1);
		tv = 1'b0;
		rc(8'h06, 8'h81);
	endtask
	task t_chan;
		i_host_model.wr_reg(8'h08, 8'h81);
		cyc(3);
		chk({cv, cerr, terr}, 12'h000);
		chk(ce, 8'h7E);
		sel = 3'd1;
		cyc(3);
		chk({cv, cerr}, 11'h7FF);
	endtask
	task t_tach;
		for (int f = 0; f < 4; f++) begin
			i_host_model.wr_reg(8'h05, {2'b00, f[1:0], f[1:0], 2'b00});
			npf = 0;
			nps = 0;
			repeat (16) begin
				{ft, st} = 2'b11;
				cyc(4);
				{ft, st} = 2'b00;
				cyc(4);
			end
			chk({npf[7:0], nps[7:0]}, {2{8'(16 >> f)}});
		end
		i_host_model.wr_reg(8'h05, 8'h07);
		cyc(4);
		chk({fl, sl}, 2'b10);
		{ft, st} = 2'b11;
		cyc(4);
		chk({fl, sl}, 2'b01);
	endtask
	task t_pace;
		i_host_model.wr_reg(8'h07, 8'h00);
		for (int k = 0; k < 2; k++) begin
			i_host_model.wr_reg(8'h0B, k[7:0]);
			for (n = 0; n < 300 && !rs; n++) cyc(1);
			cyc(1);
			for (n = 1; n < 300 && !rs; n++) cyc(1);
			chk(n >= (8 * k + 6) * UNIT && n <= (8 * k + 6) * UNIT + 1, 1);
		end
		i_host_model.wr_reg(8'h07, 8'h01);
		cyc(3);
		repeat (8) begin
			chk(rs, 1'b1);
			cyc(1);
		end
	endtask
	task report_and_stop;
		$display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		{rst, ft, st, ot, le, te} = 6'b100011;
		sel = 3'd0;
		tv = 1'b0;
		tr = 12'h000;
		rdg = 10'h3FF;
		cyc(16);
		rst = 1'b0;
		t_reset();
		t_pin();
		t_chan();
		t_tach();
		t_pace();
		report_and_stop();
	end
	// The whole run needs about two thousand cycles; this cuts a hang short.
	initial begin
		#100000;
		n_mismatch++;
		report_and_stop();
	end
endmodule // tb_monitor_config_registers
